//--- hw/clk_sel_pkg.sv
// Constants, register layout and carrier types of the sample clock select and export block
// Summary of operation
// - Eight function pins, each with its own direction bit.
// - Internal clock is the reference divided by twice a 16-bit N, N being 1 to 65535.
// - External clock taken from do_clock_pin, di_clock_pin or coax_clock_input.
// - External clocks get an 80-step phase shift, 4.5 degrees a step; internal none.
// - With phase shift off, any external clock rate is passed through unchanged.
// - Clock exported on a function pin is the selected path clock, shifted only when shift is on.
// - coax_clock_output carries the input or output path internal clock, by configuration.
// - coax_clock_input may drive either the input or the output path.
// - Each function pin takes a programmable mode, including clock in or out.
// - coax_clock_output level follows the function pin level setting.
package clk_sel_pkg;

    localparam int        NUM_PINS        = 8;
    localparam int        DO_PIN          = 6;
    localparam int        DI_PIN          = 7;
    localparam int        ADDR_W          = 5;

    localparam logic [4:0] OFS_PIN_DIR     = 5'h00;
    localparam logic [4:0] OFS_PIN_MODE    = 5'h04;
    localparam logic [4:0] OFS_DI_CFG      = 5'h08;
    localparam logic [4:0] OFS_DO_CFG      = 5'h0c;
    localparam logic [4:0] OFS_EXPORT      = 5'h10;
    localparam logic [4:0] OFS_STATUS      = 5'h14;

    localparam int        CFG_W           = 26;
    localparam int        STEPS           = 80;
    localparam logic [6:0] STEP_MAX        = 7'h4f;
    localparam int        DELAY_DEPTH     = 64;
    localparam int        PERIOD_W        = 16;
    localparam logic [15:0] DIV_MIN        = 16'h0001;

    localparam logic [7:0]  PIN_DIR_RESET  = 8'h00;
    localparam logic [23:0] PIN_MODE_RESET = 24'h000000;

    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0,
        SRC_PIN      = 2'h1,
        SRC_COAX     = 2'h2
    } clk_src_t;

    typedef enum logic [2:0] {
        MODE_SERIAL     = 3'h0,
        MODE_HANDSHAKE  = 3'h1,
        MODE_TRIG_IN    = 3'h2,
        MODE_TRIG_OUT   = 3'h3,
        MODE_DI_CLK_IN  = 3'h4,
        MODE_DI_CLK_OUT = 3'h5,
        MODE_DO_CLK_IN  = 3'h6,
        MODE_DO_CLK_OUT = 3'h7
    } pin_mode_t;

    typedef enum logic [1:0] {
        LEVEL_1V8 = 2'h0,
        LEVEL_2V5 = 2'h1,
        LEVEL_3V3 = 2'h2
    } level_t;

    // Per-path clock configuration, bit layout of the path config registers
    typedef struct packed {
        logic [6:0]  shift_step;
        logic        shift_en;
        logic [1:0]  src;
        logic [15:0] divisor;
    } path_cfg_t;

    localparam path_cfg_t PATH_CFG_RESET = '{shift_step: 7'h00, shift_en: 1'b0,
                                             src: 2'h0, divisor: 16'h0001};

    typedef struct packed {
        logic [1:0] level;
        logic       coax_from_do;
    } export_cfg_t;

    localparam export_cfg_t EXPORT_RESET = '{level: 2'h2, coax_from_do: 1'b0};

endpackage

//--- hw/phase_shifter.sv
// Measures an external clock period and delays it by a programmable fraction of it
`timescale 1ns/100ps
module phase_shifter (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_in,
    input  wire logic        shift_en,
    input  wire logic [6:0]  shift_step,
    output logic             clk_out,
    output logic [15:0]      period
);
    logic [15:0]                          count_reg;
    logic [15:0]                          period_reg;
    logic                                 prev_reg;
    logic [clk_sel_pkg::DELAY_DEPTH-2:0]  line_reg;
    logic [clk_sel_pkg::DELAY_DEPTH-1:0]  delayed;
    logic                                 out_reg;
    logic [6:0]                           step_clamped;
    logic [22:0]                          product;
    logic [22:0]                          tap_full;
    logic [5:0]                           tap;
    logic                                 rise;

    assign rise         = clk_in & ~prev_reg;
    assign step_clamped = (shift_step > clk_sel_pkg::STEP_MAX) ? clk_sel_pkg::STEP_MAX
                                                              : shift_step;
    // Delay is period * step / 80, one step being 4.5 degrees
    assign product      = 23'(period_reg) * 23'(step_clamped);
    assign tap_full     = product / 23'(clk_sel_pkg::STEPS);
    // Delay line is finite, so very slow clocks get a clamped shift
    assign tap          = (tap_full > 23'(clk_sel_pkg::DELAY_DEPTH - 1)) ? 6'h3f
                                                                         : tap_full[5:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg  <= 16'h0000;
            period_reg <= 16'h0000;
            prev_reg   <= 1'b0;
            line_reg   <= '0;
            out_reg    <= 1'b0;
        end else begin
            prev_reg   <= clk_in;
            line_reg   <= {line_reg[clk_sel_pkg::DELAY_DEPTH-3:0], clk_in};
            if (rise) begin
                period_reg <= count_reg + 16'h0001;
                count_reg  <= 16'h0000;
            end else if (count_reg != 16'hffff) begin
                count_reg  <= count_reg + 16'h0001;
            end
            out_reg    <= shift_en ? delayed[tap] : clk_in;
        end
    end

    // Tap zero is the input itself, so step zero adds no delay
    assign delayed = {line_reg, clk_in};
    assign clk_out = out_reg;
    assign period  = period_reg;
endmodule

//--- hw/sample_clock_select_export.sv
// Sample clock generation, source select, phase shift and export with AHB-Lite registers
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module sample_clock_select_export (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  function_pins_in,
    output logic [7:0]       function_pins_out,
    output logic [7:0]       function_pins_oe,
    input  wire logic        coax_clock_input,
    output logic             coax_clock_output,
    output logic [1:0]       coax_level,
    output logic             di_sample_clk,
    output logic             do_sample_clk
);
    // Register file
    logic [7:0]               pin_dir_reg;
    logic [23:0]              pin_mode_reg;
    clk_sel_pkg::path_cfg_t   di_cfg_reg;
    clk_sel_pkg::path_cfg_t   do_cfg_reg;
    clk_sel_pkg::export_cfg_t export_reg;

    // Bus state
    logic                     wr_pend_reg;
    logic [4:0]               wr_addr_reg;
    logic [31:0]              rdata_reg;
    logic                     ready_reg;

    // Pin synchronisers
    logic [7:0]               pins_meta_reg;
    logic [7:0]               pins_sync_reg;
    logic                     coax_meta_reg;
    logic                     coax_sync_reg;

    // Internal dividers
    logic [15:0]              di_cnt_reg;
    logic [15:0]              do_cnt_reg;
    logic                     di_int_reg;
    logic                     do_int_reg;

    // Output stage
    logic                     di_clk_reg;
    logic                     do_clk_reg;
    logic                     coax_out_reg;
    logic [1:0]               coax_level_reg;
    logic [7:0]               pins_out_reg;
    logic [7:0]               pins_oe_reg;

    logic                     addr_phase;
    logic [4:0]               addr_ofs;
    logic                     addr_in_map;
    logic [31:0]              rdata_next;
    logic [15:0]              wr_divisor;
    clk_sel_pkg::path_cfg_t   wr_cfg;
    logic                     wr_pin_dir;
    logic                     wr_pin_mode;
    logic                     wr_di_cfg;
    logic                     wr_do_cfg;
    logic                     wr_export;
    logic [15:0]              di_div;
    logic [15:0]              do_div;
    logic                     di_ext_raw;
    logic                     do_ext_raw;
    logic                     di_selected;
    logic                     do_selected;
    logic                     di_shift_en;
    logic                     do_shift_en;
    logic                     di_is_ext;
    logic                     do_is_ext;
    logic                     di_shifted;
    logic                     do_shifted;
    logic [15:0]              di_period;
    logic [15:0]              do_period;
    logic [7:0]               pins_out_next;

    // Bus decode
    assign addr_phase  = hsel & hready & (htrans == clk_sel_pkg::HTRANS_NONSEQ);
    assign addr_ofs    = haddr[4:0];
    assign addr_in_map = (haddr[31:5] == 27'h0000000);

    always_comb begin
        rdata_next = 32'h00000000;
        if (addr_in_map) begin
            case (addr_ofs)
                clk_sel_pkg::OFS_PIN_DIR:  rdata_next = {24'h000000, pin_dir_reg};
                clk_sel_pkg::OFS_PIN_MODE: rdata_next = {8'h00, pin_mode_reg};
                clk_sel_pkg::OFS_DI_CFG:   rdata_next = {6'h00, di_cfg_reg};
                clk_sel_pkg::OFS_DO_CFG:   rdata_next = {6'h00, do_cfg_reg};
                clk_sel_pkg::OFS_EXPORT:   rdata_next = {29'h00000000, export_reg};
                clk_sel_pkg::OFS_STATUS:   rdata_next = {do_period, di_period};
                default:                   rdata_next = 32'h00000000;
            endcase
        end
    end

    assign wr_pin_dir  = wr_pend_reg & (wr_addr_reg == clk_sel_pkg::OFS_PIN_DIR);
    assign wr_pin_mode = wr_pend_reg & (wr_addr_reg == clk_sel_pkg::OFS_PIN_MODE);
    assign wr_di_cfg   = wr_pend_reg & (wr_addr_reg == clk_sel_pkg::OFS_DI_CFG);
    assign wr_do_cfg   = wr_pend_reg & (wr_addr_reg == clk_sel_pkg::OFS_DO_CFG);
    assign wr_export   = wr_pend_reg & (wr_addr_reg == clk_sel_pkg::OFS_EXPORT);

    // A zero divisor would stall the clock, so it is stored as one
    assign wr_divisor  = (hwdata[15:0] == 16'h0000) ? clk_sel_pkg::DIV_MIN : hwdata[15:0];
    assign wr_cfg      = clk_sel_pkg::path_cfg_t'({hwdata[25:16], wr_divisor});

    // Zero wait states: reads are registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 5'h00;
            rdata_reg   <= 32'h00000000;
            ready_reg   <= 1'b0;
        end else begin
            ready_reg   <= 1'b1;
            wr_pend_reg <= addr_phase & hwrite & addr_in_map;
            wr_addr_reg <= addr_ofs;
            if (addr_phase && !hwrite) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Writes act in the data phase, while hwdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_dir_reg  <= clk_sel_pkg::PIN_DIR_RESET;
            pin_mode_reg <= clk_sel_pkg::PIN_MODE_RESET;
        end else begin
            if (wr_pin_dir) begin
                pin_dir_reg <= hwdata[7:0];
            end
            if (wr_pin_mode) begin
                pin_mode_reg <= hwdata[23:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            di_cfg_reg   <= clk_sel_pkg::PATH_CFG_RESET;
            do_cfg_reg   <= clk_sel_pkg::PATH_CFG_RESET;
            export_reg   <= clk_sel_pkg::EXPORT_RESET;
        end else begin
            if (wr_di_cfg) begin
                di_cfg_reg <= wr_cfg;
            end
            if (wr_do_cfg) begin
                do_cfg_reg <= wr_cfg;
            end
            if (wr_export) begin
                export_reg <= clk_sel_pkg::export_cfg_t'(hwdata[2:0]);
            end
        end
    end

    // Two flops on every pin before any logic sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta_reg <= 8'h00;
            pins_sync_reg <= 8'h00;
            coax_meta_reg <= 1'b0;
            coax_sync_reg <= 1'b0;
        end else begin
            pins_meta_reg <= function_pins_in;
            pins_sync_reg <= pins_meta_reg;
            coax_meta_reg <= coax_clock_input;
            coax_sync_reg <= coax_meta_reg;
        end
    end

    // Internal dividers toggle every N clocks; belt and braces against zero
    assign di_div = (di_cfg_reg.divisor == 16'h0000) ? clk_sel_pkg::DIV_MIN
                                                     : di_cfg_reg.divisor;
    assign do_div = (do_cfg_reg.divisor == 16'h0000) ? clk_sel_pkg::DIV_MIN
                                                     : do_cfg_reg.divisor;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            di_cnt_reg <= 16'h0000;
            di_int_reg <= 1'b0;
        end else begin
            if (di_cnt_reg >= di_div - 16'h0001) begin
                di_cnt_reg <= 16'h0000;
                di_int_reg <= ~di_int_reg;
            end else begin
                di_cnt_reg <= di_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            do_cnt_reg <= 16'h0000;
            do_int_reg <= 1'b0;
        end else begin
            if (do_cnt_reg >= do_div - 16'h0001) begin
                do_cnt_reg <= 16'h0000;
                do_int_reg <= ~do_int_reg;
            end else begin
                do_cnt_reg <= do_cnt_reg + 16'h0001;
            end
        end
    end

    // One source per path; an unused code falls back to the divider
    always_comb begin
        case (clk_sel_pkg::clk_src_t'(di_cfg_reg.src))
            clk_sel_pkg::SRC_PIN:  di_ext_raw = pins_sync_reg[clk_sel_pkg::DI_PIN];
            clk_sel_pkg::SRC_COAX: di_ext_raw = coax_sync_reg;
            default:               di_ext_raw = 1'b0;
        endcase
        case (clk_sel_pkg::clk_src_t'(do_cfg_reg.src))
            clk_sel_pkg::SRC_PIN:  do_ext_raw = pins_sync_reg[clk_sel_pkg::DO_PIN];
            clk_sel_pkg::SRC_COAX: do_ext_raw = coax_sync_reg;
            default:               do_ext_raw = 1'b0;
        endcase
    end

    assign di_is_ext   = (di_cfg_reg.src == clk_sel_pkg::SRC_PIN)
                       | (di_cfg_reg.src == clk_sel_pkg::SRC_COAX);
    assign do_is_ext   = (do_cfg_reg.src == clk_sel_pkg::SRC_PIN)
                       | (do_cfg_reg.src == clk_sel_pkg::SRC_COAX);

    // Phase shift is only offered on external sources
    assign di_shift_en = di_cfg_reg.shift_en & di_is_ext;
    assign do_shift_en = do_cfg_reg.shift_en & do_is_ext;

    phase_shifter u_di_shift (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_in     (di_ext_raw),
        .shift_en   (di_shift_en),
        .shift_step (di_cfg_reg.shift_step),
        .clk_out    (di_shifted),
        .period     (di_period)
    );

    phase_shifter u_do_shift (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_in     (do_ext_raw),
        .shift_en   (do_shift_en),
        .shift_step (do_cfg_reg.shift_step),
        .clk_out    (do_shifted),
        .period     (do_period)
    );

    // Shift relies on a free-running external clock, else the period reads stale
    assign di_selected = di_is_ext ? di_shifted : di_int_reg;
    assign do_selected = do_is_ext ? do_shifted : do_int_reg;

    // Pins in a clock-out mode export the path clock; other modes belong elsewhere
    always_comb begin
        pins_out_next = 8'h00;
        for (int i = 0; i < clk_sel_pkg::NUM_PINS; i++) begin
            case (clk_sel_pkg::pin_mode_t'(pin_mode_reg[3*i +: 3]))
                clk_sel_pkg::MODE_DI_CLK_OUT: pins_out_next[i] = di_selected;
                clk_sel_pkg::MODE_DO_CLK_OUT: pins_out_next[i] = do_selected;
                default:                      pins_out_next[i] = 1'b0;
            endcase
        end
    end

    // Coax export takes only an internal divider clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            di_clk_reg     <= 1'b0;
            do_clk_reg     <= 1'b0;
            coax_out_reg   <= 1'b0;
            coax_level_reg <= clk_sel_pkg::EXPORT_RESET.level;
        end else begin
            di_clk_reg     <= di_selected;
            do_clk_reg     <= do_selected;
            coax_out_reg   <= export_reg.coax_from_do ? do_int_reg : di_int_reg;
            coax_level_reg <= export_reg.level;
        end
    end

    // Enables follow direction alone, so a mode never turns a driver on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_out_reg   <= 8'h00;
            pins_oe_reg    <= 8'h00;
        end else begin
            pins_out_reg   <= pins_out_next;
            pins_oe_reg    <= pin_dir_reg;
        end
    end

    assign hrdata            = rdata_reg;
    assign hreadyout         = ready_reg;
    assign hresp             = 1'b0;
    assign function_pins_out = pins_out_reg;
    assign function_pins_oe  = pins_oe_reg;
    assign coax_clock_output = coax_out_reg;
    assign coax_level        = coax_level_reg;
    assign di_sample_clk     = di_clk_reg;
    assign do_sample_clk     = do_clk_reg;
endmodule

//--- verif/ext_clock_source.sv
// External instrument model driving free-running sample clocks
`timescale 1ns/100ps
module ext_clock_source (
    input  wire logic run,
    output logic      di_ext,
    output logic      do_ext,
    output logic      coax_ext
);
    initial begin
        di_ext = 1'b0;
        do_ext = 1'b0;
        coax_ext = 1'b0;
    end
    // Stands still until started, then runs with no gaps
    always #100 if (run) di_ext = !di_ext;
    always #150 if (run) do_ext = !do_ext;
    always #125 if (run) coax_ext = !coax_ext;
endmodule

//--- verif/sample_clock_select_export_asserts.sv
// Concurrent checks on the register bus and pin control outputs
`timescale 1ns/100ps
module sample_clock_select_export_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  function_pins_oe,
    input wire logic [1:0]  coax_level
);
    logic        acc;
    logic        wr_seen;
    logic        wr_done;
    logic [4:0]  wr_ofs;
    logic [31:0] wr_val;
    assign acc = hsel && hready && htrans == clk_sel_pkg::HTRANS_NONSEQ;
    // Write data is kept one cycle past its data phase so effects can be timed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_seen <= 1'b0;
            wr_done <= 1'b0;
            wr_ofs  <= 5'h00;
            wr_val  <= 32'h0;
        end else begin
            wr_seen <= acc && hwrite && haddr[31:5] == 27'h0;
            wr_done <= wr_seen;
            if (acc && hwrite) wr_ofs <= haddr[4:0];
            if (wr_seen) wr_val <= hwdata;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [4:0] a);
        acc && !hwrite && haddr == {27'h0, a};
    endsequence
    sequence s_wr(logic [4:0] a);
        wr_done && wr_ofs == a;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout == 1'b1)
        else $error("wait state inserted");
    a_dir_to_oe: assert property (
        s_wr(clk_sel_pkg::OFS_PIN_DIR) |-> ##[1:2] function_pins_oe == wr_val[7:0])
        else $error("pin enables do not follow direction");
    a_level_out: assert property (
        s_wr(clk_sel_pkg::OFS_EXPORT) |-> ##[1:2] coax_level == wr_val[2:1])
        else $error("coax level does not follow setting");
    a_div_nonzero: assert property (
        (s_rd(clk_sel_pkg::OFS_DI_CFG) or s_rd(clk_sel_pkg::OFS_DO_CFG))
        |=> hrdata[15:0] != 16'h0) else $error("zero divisor stored");
    a_dir_width: assert property (
        s_rd(clk_sel_pkg::OFS_PIN_DIR) |=> hrdata[31:8] == 24'h0)
        else $error("direction has extra bits");
    a_unmapped_zero: assert property (acc && !hwrite && haddr >= 32'h18 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_vals: assert property (
        $rose(hresetn) |-> $past(coax_level) == 2'h2 && $past(function_pins_oe) == 8'h0)
        else $error("wrong output reset values");
    a_rdata_holds: assert property (!(acc && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without read");
endmodule

//--- verif/sample_clock_select_export_test.sv
// Self-checking bench for the sample clock select and export block
`timescale 1ns/100ps
module sample_clock_select_export_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        rd_phase = 1'b0;
    logic        run = 1'b0;
    logic [5:0]  pat = 6'h00;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  function_pins_in;
    logic [7:0]  function_pins_out;
    logic [7:0]  function_pins_oe;
    logic        coax_clock_output;
    logic [1:0]  coax_level;
    logic        di_sample_clk;
    logic        do_sample_clk;
    logic        di_ext;
    logic        do_ext;
    logic        coax_ext;
    logic [4:0]  taps;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic [31:0] v;
    logic [6:0]  stp[2] = '{7'h14, 7'h78};
    int          tbl[8] = '{6, 8, 10, 6, 10, 12, 10, 10};
    int          errors = 0;
    int          samples_checked = 0;
    int          seed;
    int          n;
    int          l0;
    int          d;
    always #12.5 hclk = !hclk;
    // Pin wire: device level where it drives, instrument level elsewhere
    assign function_pins_in = (function_pins_oe & function_pins_out)
                            | (~function_pins_oe & {di_ext, do_ext, pat});
    assign taps = {di_ext, function_pins_out[0], coax_clock_output, do_sample_clk, di_sample_clk};
    always @(posedge hclk) pat <= 6'($urandom);
    sample_clock_select_export sample_clock_select_export_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .function_pins_in,
        .function_pins_out, .function_pins_oe, .coax_clock_input(coax_ext),
        .coax_clock_output, .coax_level, .di_sample_clk, .do_sample_clk);
    ext_clock_source ext_clock_source_inst (.run, .di_ext, .do_ext, .coax_ext);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, e, m);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= clk_sel_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        if (!w) begin
            exp_q.push_back(e);
            mask_q.push_back(m);
        end
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] o, input logic [31:0] d);
        bus(1'b1, {27'h0, o}, d, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [4:0] o, input logic [31:0] e, m);
        bus(1'b0, {27'h0, o}, 32'h0, e, m);
    endtask
    // Read data is compared at the edge that ends its data phase
    always @(posedge hclk) begin
        if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
            chk(hrdata & mask_q.pop_front(), exp_q.pop_front());
        end
    end
    // Cycles to the next rising sample of a tap; 40 means none seen
    task automatic rise(input int s, output int c);
        logic p;
        c = 0;
        p = 1'b1;
        while (!(p === 1'b0 && taps[s] === 1'b1) && c < 40) begin
            p = taps[s];
            @(posedge hclk);
            c++;
        end
    endtask
    task automatic per(input int s, output int c);
        rise(s, c);
        rise(s, c);
    endtask
    task automatic close_out();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #500000;
        errors++;
        close_out();
    end
    initial begin
        seed = $urandom(32'h6ccf);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        run <= 1'b1;
        @(posedge hclk);
        rd(clk_sel_pkg::OFS_PIN_DIR, 32'h0, '1);
        rd(clk_sel_pkg::OFS_PIN_MODE, 32'h0, '1);
        rd(clk_sel_pkg::OFS_DI_CFG, 32'h1, '1);
        rd(clk_sel_pkg::OFS_DO_CFG, 32'h1, '1);
        rd(clk_sel_pkg::OFS_EXPORT, 32'h4, '1);
        rd(5'h18, 32'h0, '1);
        bus(1'b1, 32'h20, 32'hff, 32'h0, 32'h0);
        rd(clk_sel_pkg::OFS_PIN_DIR, 32'h0, '1);
        repeat (4) begin
            v = $urandom & 32'h3f;
            wr(clk_sel_pkg::OFS_PIN_DIR, v);
            rd(clk_sel_pkg::OFS_PIN_DIR, v, '1);
            chk({24'h0, function_pins_oe}, v);
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 2) ? $urandom_range(9, 2) : i;
            wr(clk_sel_pkg::OFS_DI_CFG, v);
            v = (v == 0) ? 32'h1 : v;
            rd(clk_sel_pkg::OFS_DI_CFG, v, '1);
            per(0, n);
            chk(32'(n), 2 * v);
        end
        wr(clk_sel_pkg::OFS_DO_CFG, 32'h5);
        wr(clk_sel_pkg::OFS_PIN_DIR, 32'h1);
        for (int m = 0; m < 8; m++) begin
            wr(clk_sel_pkg::OFS_PIN_MODE, 32'(m));
            rd(clk_sel_pkg::OFS_PIN_MODE, 32'(m), '1);
            per(3, n);
            chk(32'(n), m == 5 ? 32'h6 : m == 7 ? 32'ha : 32'h28);
        end
        for (int i = 0; i < 6; i++) begin
            v = {29'h0, 2'(i / 2), 1'(i % 2)};
            wr(clk_sel_pkg::OFS_EXPORT, v);
            rd(clk_sel_pkg::OFS_EXPORT, v, '1);
            chk({30'h0, coax_level}, 32'(i / 2));
            per(2, n);
            chk(32'(n), i % 2 ? 32'ha : 32'h6);
        end
        for (int i = 0; i < 8; i++) begin
            v = {14'h0, 2'(i % 4), i < 4 ? 16'h3 : 16'h5};
            wr(i < 4 ? clk_sel_pkg::OFS_DI_CFG : clk_sel_pkg::OFS_DO_CFG, v);
            per(i / 4, n);
            per(i / 4, n);
            chk(32'(n), 32'(tbl[i]));
        end
        wr(clk_sel_pkg::OFS_DI_CFG, 32'h10003);
        per(0, n);
        rd(clk_sel_pkg::OFS_STATUS, 32'h8, 32'hffff);
        rise(4, n);
        rise(0, l0);
        foreach (stp[i]) begin
            wr(clk_sel_pkg::OFS_DI_CFG, {6'h0, stp[i], 1'b1, 18'h10003});
            d = 8 * (stp[i] > 79 ? 79 : int'(stp[i])) / 80;
            repeat (40) @(posedge hclk);
            per(0, n);
            chk(32'(n), 32'h8);
            rise(4, n);
            rise(0, n);
            chk(32'(n), 32'((l0 + d - 1) % 8 + 1));
        end
        close_out();
    end
endmodule
bind sample_clock_select_export sample_clock_select_export_asserts
    sample_clock_select_export_asserts_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .function_pins_oe, .coax_level);
